// >>> design/spsc_regs.svh
// Constants for the standby pin-state control block.
`ifndef SPSC_REGS_SVH
`define SPSC_REGS_SVH
`define SPSC_NPINS       8
`define SPSC_SEG_MAX_BIG 6'h24
`define SPSC_SEG_MAX_SML 6'h1F
`define SPSC_SEG_FIRST   6'h06
`define SPSC_ZERO8       8'h00
`define SPSC_ONE1        1'b1
`endif

// >>> design/spsc_pkg.sv
// Types for the standby pin-state control block.
package spsc_pkg;
   typedef enum logic [1:0] {
      SPSC_RUN,
      SPSC_HOLD,
      SPSC_HIZ
   } spsc_state_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } spsc_drive_t;

   typedef enum logic [1:0] {
      SPSC_MODE_NORMAL,
      SPSC_MODE_SLEEP,
      SPSC_MODE_STOP,
      SPSC_MODE_WATCH
   } spsc_mode_t;
endpackage

// >>> design/spsc_sync.sv
// Two-flop synchroniser for the pin input levels.
`timescale 1ns/1ps
module spsc_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule

// >>> design/spsc_top.sv
// Standby pin-state control for one shared port group.
// Contract
// - Normal and sleep leave pins untouched.
// - Stop/watch, select zero: hold, block input.
// - Select one: Hi-Z; LCD pins Hi-Z at reset.
// - Timer pins at reset: Hi-Z, input reaches interrupts only.
// - Pull-up control stays effective in standby.
// - Blocked input stops pin reaching logic.
// - Enabled external interrupts still pass through.
// - Comparator output keeps driving in standby.
// - Segment range depends on product variant.
`timescale 1ns/1ps
`include "spsc_regs.svh"
module spsc_top #(
   parameter int  NPINS       = `SPSC_NPINS,
   parameter bit  BIG_VARIANT = 1'b1,
   parameter logic [NPINS-1:0] LCD_GROUP = '1,
   parameter logic [NPINS-1:0] CMP_PIN   = '0
) (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire spsc_pkg::spsc_mode_t mode,
   input  wire logic                 pin_state_select,
   input  wire spsc_pkg::spsc_drive_t core_drive,
   input  wire logic [NPINS-1:0]     pullup_cfg,
   input  wire logic [NPINS-1:0]     ext_int_en,
   input  wire logic [NPINS-1:0]     pin_in,
   input  wire logic [5:0]           seg_index,
   output logic      [NPINS-1:0]     pin_out,
   output logic      [NPINS-1:0]     pin_oe,
   output logic      [NPINS-1:0]     pin_pullup,
   output logic      [NPINS-1:0]     core_in,
   output logic      [NPINS-1:0]     ext_int_in,
   output logic                      seg_valid,
   output spsc_pkg::spsc_state_t     pin_state
);
   // ==========================================
   // Input synchronisation
   logic [NPINS-1:0] pin_sync;

   spsc_sync #(.WIDTH(NPINS)) u_sync (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // ==========================================
   // Standby state machine
   spsc_pkg::spsc_state_t state_q;
   spsc_pkg::spsc_state_t state_d;
   logic                  standby;
   logic                  rst_seen_q;
   logic                  rst_seen_d;

   assign standby = (mode == spsc_pkg::SPSC_MODE_STOP) ||
                    (mode == spsc_pkg::SPSC_MODE_WATCH);

   always_comb begin
      state_d    = state_q;
      rst_seen_d = `SPSC_ONE1;
      unique case (state_q)
         spsc_pkg::SPSC_RUN: begin
            // The select bit is only looked at on the entry edge.
            if (standby) begin
               state_d = pin_state_select ? spsc_pkg::SPSC_HIZ : spsc_pkg::SPSC_HOLD;
            end
         end
         spsc_pkg::SPSC_HOLD, spsc_pkg::SPSC_HIZ: begin
            if (!standby) begin
               state_d = spsc_pkg::SPSC_RUN;
            end
         end
         default: state_d = spsc_pkg::SPSC_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q    <= spsc_pkg::SPSC_RUN;
         rst_seen_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         rst_seen_q <= rst_seen_d;
      end
   end

   // ==========================================
   // Pin drive and input gating
   logic [NPINS-1:0] out_q, out_d;
   logic [NPINS-1:0] oe_q, oe_d;
   logic [NPINS-1:0] pu_q, pu_d;
   logic [NPINS-1:0] cin_q, cin_d;
   logic [NPINS-1:0] eint_q, eint_d;
   logic             segv_q, segv_d;
   logic [5:0]       seg_max;

   assign seg_max = BIG_VARIANT ? `SPSC_SEG_MAX_BIG : `SPSC_SEG_MAX_SML;

   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         always_comb begin
            out_d[gi]  = core_drive.out[gi];
            oe_d[gi]   = core_drive.oe[gi];
            cin_d[gi]  = pin_sync[gi];
            eint_d[gi] = pin_sync[gi] & ext_int_en[gi];
            pu_d[gi]   = pullup_cfg[gi];
            if (!rst_seen_q) begin
               // Out of reset the pin floats; timer pins keep input enabled
               // and pass it to the interrupt path only, LCD pins block it.
               out_d[gi] = 1'b0;
               oe_d[gi]  = 1'b0;
               cin_d[gi] = 1'b0;
            end else if (state_q == spsc_pkg::SPSC_HOLD) begin
               out_d[gi] = out_q[gi];
               oe_d[gi]  = oe_q[gi];
               cin_d[gi] = 1'b0;
            end else if (state_q == spsc_pkg::SPSC_HIZ) begin
               oe_d[gi]  = 1'b0;
               out_d[gi] = 1'b0;
               cin_d[gi] = 1'b0;
            end
            // Comparator output is live in every standby state.
            if (CMP_PIN[gi] && rst_seen_q) begin
               out_d[gi] = core_drive.out[gi];
               oe_d[gi]  = core_drive.oe[gi];
            end
            // Interrupt path bypasses the input block on purpose.
            if (LCD_GROUP[gi] && !rst_seen_q) begin
               eint_d[gi] = 1'b0;
            end
         end
      end
   endgenerate

   always_comb begin
      segv_d = (seg_index >= `SPSC_SEG_FIRST) && (seg_index <= seg_max);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         out_q  <= '0;
         oe_q   <= '0;
         pu_q   <= '0;
         cin_q  <= '0;
         eint_q <= '0;
         segv_q <= 1'b0;
      end else begin
         out_q  <= out_d;
         oe_q   <= oe_d;
         pu_q   <= pu_d;
         cin_q  <= cin_d;
         eint_q <= eint_d;
         segv_q <= segv_d;
      end
   end

   assign pin_out    = out_q;
   assign pin_oe     = oe_q;
   assign pin_pullup = pu_q;
   assign core_in    = cin_q;
   assign ext_int_in = eint_q;
   assign seg_valid  = segv_q;
   assign pin_state  = state_q;

   // ==========================================
   // Checks
   hold_keeps_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_HOLD) && $past(state_q == spsc_pkg::SPSC_HOLD)
      |=> $stable(pin_out & ~CMP_PIN)) else $error("hold lost pin value");
   hold_oe_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_HOLD) && $past(state_q == spsc_pkg::SPSC_HOLD)
      |=> $stable(pin_oe & ~CMP_PIN)) else $error("hold lost pin enable");
   // Entry with the select bit low must freeze the pins, never float them.
   hold_entry_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_RUN) && standby && !pin_state_select
      |=> (state_q == spsc_pkg::SPSC_HOLD)) else $error("hold not entered");
   hiz_floats_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_HIZ) |=> ((pin_oe & ~CMP_PIN) == '0))
      else $error("hiz pin driven");
   // The first cycle after reset floats every pin, so no stale level leaks out.
   reset_float_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !rst_seen_q |=> ((pin_oe == '0) && (core_in == '0)))
      else $error("reset pin not floating");
   input_block_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q != spsc_pkg::SPSC_RUN) |=> (core_in == '0))
      else $error("blocked input leaked");
   run_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_RUN) && rst_seen_q
      |=> (pin_oe == $past(core_drive.oe))) else $error("run drive altered");
   entry_sample_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_RUN) && standby && pin_state_select
      |=> (state_q == spsc_pkg::SPSC_HIZ)) else $error("select not sampled");
   exit_release_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q != spsc_pkg::SPSC_RUN) && !standby
      |=> (state_q == spsc_pkg::SPSC_RUN)) else $error("no release");
   pullup_kept_a: assert property (@(posedge mclk) disable iff (!reset_n)
      1'b1 |=> (pin_pullup == $past(pullup_cfg))) else $error("pullup overridden");
   irq_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rst_seen_q |=> (ext_int_in == $past(pin_sync & ext_int_en)))
      else $error("interrupt blocked");
   seg_range_a: assert property (@(posedge mclk) disable iff (!reset_n)
      1'b1 |=> (seg_valid == (($past(seg_index) >= `SPSC_SEG_FIRST) &&
      ($past(seg_index) <= seg_max)))) else $error("segment range wrong");
   // The comparator pin is exempt from freezing so its level stays visible.
   cmp_live_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rst_seen_q |=> ((pin_out & CMP_PIN) == ($past(core_drive.out) & CMP_PIN)))
      else $error("comparator frozen");

   // Covers for the main scenarios.
   hold_c: cover property (@(posedge mclk) disable iff (!reset_n)
      state_q == spsc_pkg::SPSC_HOLD);
   hiz_c: cover property (@(posedge mclk) disable iff (!reset_n)
      state_q == spsc_pkg::SPSC_HIZ);
   wake_c: cover property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_HIZ) ##1 (state_q == spsc_pkg::SPSC_RUN));
   sleep_c: cover property (@(posedge mclk) disable iff (!reset_n)
      (mode == spsc_pkg::SPSC_MODE_SLEEP) && (state_q == spsc_pkg::SPSC_RUN));
   hold_wake_c: cover property (@(posedge mclk) disable iff (!reset_n)
      (state_q == spsc_pkg::SPSC_HOLD) ##1 (state_q == spsc_pkg::SPSC_RUN));
endmodule

// >>> dv/spsc_board.sv
// Board-side model that resolves the level seen on each shared pin.
`timescale 1ns/1ps
module spsc_board (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_level,
   output logic      [7:0] pin_level
);
   // ==========================================================
   // Pin resolution
   // The board always pulls or drives each pin, so a released pin never floats.
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> dv/tb_spsc_top.sv
// Self-checking testbench for the standby pin-state control block.
`timescale 1ns/1ps
module tb_spsc_top;
   logic                  mclk, reset_n, sel, segv;
   spsc_pkg::spsc_mode_t  mode;
   spsc_pkg::spsc_drive_t drv;
   logic [7:0]            pu, ien, pin, ext, pout, poe, ppu, cin, eint;
   logic [5:0]            lcd_segment_output;
   spsc_pkg::spsc_state_t st;
   int                    err_count, total_checks, cyc;

   spsc_top #(.CMP_PIN(8'h80)) dut (.mclk(mclk), .reset_n(reset_n), .mode(mode),
      .pin_state_select(sel), .core_drive(drv), .pullup_cfg(pu), .ext_int_en(ien),
      .pin_in(pin), .seg_index(lcd_segment_output), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
      .core_in(cin), .ext_int_in(eint), .seg_valid(segv), .pin_state(st));
   spsc_board board (.pin_out(pout), .pin_oe(poe), .ext_level(ext), .pin_level(pin));

   // ==========================================================
   // Helpers
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", err_count, total_checks);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_run;
      for (int i = 0; i < 8; i++) begin
         mode = (i % 2) ? spsc_pkg::SPSC_MODE_SLEEP : spsc_pkg::SPSC_MODE_NORMAL;
         drv = '{out: 8'h5A ^ 8'(i), oe: 8'h0F}; ext = 8'hC3; pu = 8'h33; ien = 8'hFF;
         tick(4);
         chk("run out", drv.out, pout);
         chk("run oe", drv.oe, poe);
         chk("run in", (drv.oe & drv.out) | (~drv.oe & ext), cin);
      end
   endtask
   task automatic t_hold;
      drv = '{out: 8'hA5, oe: 8'hF0}; tick(4);
      sel = 1'b0; mode = spsc_pkg::SPSC_MODE_STOP; tick(4);
      chk("hold state", 8'(spsc_pkg::SPSC_HOLD), 8'(st));
      drv = '{out: 8'h00, oe: 8'h00}; pu = 8'h0F; ien = 8'h3C; ext = 8'h55; tick(4);
      chk("hold out", 8'h25, pout);
      chk("hold oe", 8'h70, poe);
      chk("hold in", 8'h00, cin);
      chk("hold pull", 8'h0F, ppu);
      chk("hold int", ((8'h70 & 8'h25) | (8'h8F & 8'h55)) & 8'h3C, eint);
      sel = 1'b1; tick(3);
      chk("hold sel", 8'h70, poe);
      mode = spsc_pkg::SPSC_MODE_NORMAL; tick(4);
      chk("exit state", 8'(spsc_pkg::SPSC_RUN), 8'(st));
      chk("exit oe", 8'h00, poe);
   endtask
   task automatic t_hiz;
      drv = '{out: 8'hFF, oe: 8'hFF}; ext = 8'h0A; ien = 8'hFF; pu = 8'hF0; tick(2);
      sel = 1'b1; mode = spsc_pkg::SPSC_MODE_WATCH; tick(5);
      chk("hiz state", 8'(spsc_pkg::SPSC_HIZ), 8'(st));
      chk("hiz oe", 8'h80, poe);
      chk("hiz in", 8'h00, cin);
      chk("hiz pull", 8'hF0, ppu);
      chk("hiz int", 8'h8A, eint);
      drv.out = 8'h7F; sel = 1'b0; tick(3);
      chk("cmp out", 8'h00, pout & 8'h80);
      chk("hiz sel", 8'(spsc_pkg::SPSC_HIZ), 8'(st));
      mode = spsc_pkg::SPSC_MODE_NORMAL; tick(4);
      chk("back oe", 8'hFF, poe);
   endtask
   task automatic t_seg;
      logic [5:0] idx [4];
      logic       exp [4];
      idx = '{6'h05, 6'h06, 6'h24, 6'h25};
      exp = '{1'b0, 1'b1, 1'b1, 1'b0};
      foreach (idx[i]) begin
         lcd_segment_output = idx[i]; tick(2);
         chk("seg valid", 8'(exp[i]), 8'(segv));
      end
   endtask

   // ==========================================================
   // Clock, timeout and main sequence
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      reset_n = 1'b0; sel = 1'b0; mode = spsc_pkg::SPSC_MODE_NORMAL;
      drv = '{out: 8'hFF, oe: 8'hFF}; pu = 8'h00; ien = 8'hFF; ext = 8'h3C; lcd_segment_output = 6'h00;
      tick(6);
      chk("reset oe", 8'h00, poe);
      chk("reset in", 8'h00, cin);
      reset_n = 1'b1; tick(2);
      t_run();
      t_hold();
      t_hiz();
      t_seg();
      report_and_stop();
   end
endmodule
